// ==== hdl/amc_pkg.sv ====
// Purpose: Shared constants and types for the ADC mode, clock and oversampling registers.
// Assumes: Registers are 8 bits wide and addressed by a 4-bit register index.
// Notes:   Every offset, field position and register reset value lives here; the lookup tables are in the register block.
package amc_pkg;

    // Register indices on the serial register port.
    localparam logic [3:0] ADDR_MODE_CLOCK_BIAS = 4'h1;
    localparam logic [3:0] ADDR_PRESCALE_OSR    = 4'h2;

    // Reset values: guard bits set, everything else cleared; ratio code 0011.
    localparam logic [7:0] RST_MODE_CLOCK_BIAS  = 8'hC0;
    localparam logic [7:0] RST_PRESCALE_OSR     = 8'h0C;
    localparam logic [7:0] READ_UNMAPPED        = 8'h00;

    // Field positions in the first configuration register.
    localparam int GUARD_MSB = 7;
    localparam int GUARD_LSB = 6;
    localparam int CLKSEL_MSB = 5;
    localparam int CLKSEL_LSB = 4;
    localparam int BIAS_MSB = 3;
    localparam int BIAS_LSB = 2;
    localparam int MODE_MSB = 1;
    localparam int MODE_LSB = 0;

    // Field positions in the second configuration register.
    localparam int PRE_MSB = 7;
    localparam int PRE_LSB = 6;
    localparam int OSR_MSB = 5;
    localparam int OSR_LSB = 2;

    // Sensor bias currents in nanoamps.
    localparam logic [13:0] BIAS_NA_HIGH = 14'h3A98;  // 15 uA.
    localparam logic [13:0] BIAS_NA_MID  = 14'h0E74;  // 3.7 uA.
    localparam logic [13:0] BIAS_NA_LOW  = 14'h0384;  // 0.9 uA.
    localparam logic [13:0] BIAS_NA_OFF  = 14'h0000;

    // Operating mode field encodings.
    typedef enum logic [1:0] {
        MODE_SHUTDOWN_A = 2'b00,
        MODE_SHUTDOWN_B = 2'b01,
        MODE_STANDBY    = 2'b10,
        MODE_CONVERT    = 2'b11
    } amc_mode_t;

    // Clock source field encodings.
    typedef enum logic [1:0] {
        CLK_EXTERNAL_A  = 2'b00,
        CLK_EXTERNAL_B  = 2'b01,
        CLK_INTERNAL    = 2'b10,
        CLK_INTERNAL_OUT = 2'b11
    } amc_clksel_t;

    // Register port request.
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [3:0] addr;
        logic [7:0] wrData;
    } amc_req_t;

    // Decoded controls that leave the block.
    typedef struct packed {
        logic        convEn;
        logic        standby;
        logic        shutdown;
        logic        fullShutdown;
        logic        internalClock;
        logic [13:0] biasNanoAmp;
        logic [3:0]  prescaleDivisor;
        logic [16:0] oversamplingRatio;
    } amc_ctrl_t;

    // Whole state of the register block.
    typedef struct packed {
        logic [7:0] modeClockBiasConfig;
        logic [7:0] prescaleOversampleConfig;
        logic [2:0] divCnt;
        logic       analogMasterClockTick;
        logic       clkPinOut;
        logic       clkPinOe;
        logic [7:0] rdData;
        amc_ctrl_t  ctrl;
    } amc_state_t;

endpackage : amc_pkg

// ==== hdl/amc_config_regs.sv ====
// Purpose: Mode, clock-source, bias, prescaler and oversampling configuration registers.
// Assumes: Register requests arrive already deserialised from the serial port, one per cycle.
// Notes:   Outputs are registered; controls follow a write at the edge that takes it, the divider one edge later.
//
// Overview of operation
// - Guard bits are plain storage; full shutdown only when whole first register is zero.
// - Clock code 11 uses internal oscillator and drives the analog master clock tick stream on pin.
// - Clock code 10 uses internal oscillator and leaves the clock pin undriven.
// - Clock codes 01 and 00 take external clock from the pin; 00 at reset.
// - Bias code 11/10/01/00 gives 15, 3.7, 0.9 uA or no current.
// - Mode code 11 in bits 1-0 enables conversions.
// - Mode code 10 is standby with no conversions.
// - Mode codes 01 and 00 are shutdown; 00 at reset.
`timescale 1ns/100ps
module amc_config_regs (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire amc_pkg::amc_req_t  regReq,
    output logic [7:0]              regRdData,
    input  wire logic               clkPinIn,
    output logic                    clkPinOut,
    output logic                    clkPinOe,
    output logic                    analogMasterClockTick,
    output amc_pkg::amc_ctrl_t      ctrl
);

    amc_pkg::amc_state_t stateQ;
    amc_pkg::amc_state_t stateD;

    // Ratio lookup; codes between the documented end points follow the part's table.
    function automatic logic [16:0] osrOf(input logic [3:0] code);
        case (code)
            4'h0:    osrOf = 17'h00020;
            4'h1:    osrOf = 17'h00040;
            4'h2:    osrOf = 17'h00080;
            4'h3:    osrOf = 17'h00100;
            4'h4:    osrOf = 17'h00200;
            4'h5:    osrOf = 17'h00400;
            4'h6:    osrOf = 17'h00800;
            4'h7:    osrOf = 17'h01000;
            4'h8:    osrOf = 17'h02000;
            4'h9:    osrOf = 17'h04000;
            4'hA:    osrOf = 17'h05000;
            4'hB:    osrOf = 17'h06000;
            4'hC:    osrOf = 17'h0A000;
            4'hD:    osrOf = 17'h0C000;
            4'hE:    osrOf = 17'h14000;
            default: osrOf = 17'h18000;
        endcase
    endfunction : osrOf

    // Mask of low divider bits that must all be set for a tick.
    function automatic logic [2:0] preMask(input logic [1:0] code);
        case (code)
            2'b00:   preMask = 3'h0;
            2'b01:   preMask = 3'h1;
            2'b10:   preMask = 3'h3;
            default: preMask = 3'h7;
        endcase
    endfunction : preMask

    logic [7:0]  cfg0Next;
    logic [7:0]  cfg1Next;
    logic [1:0]  modeCode;
    logic [1:0]  clkCode;
    logic [1:0]  preCode;
    logic [2:0]  mask;

    // Next-state logic: register writes, decode of the new values, divider and read data.
    always_comb begin
        stateD   = stateQ;
        cfg0Next = stateQ.modeClockBiasConfig;
        cfg1Next = stateQ.prescaleOversampleConfig;
        // Unmapped addresses are ignored on write and read back as zero.
        if (regReq.wrEn && regReq.addr == amc_pkg::ADDR_MODE_CLOCK_BIAS) begin
            cfg0Next = regReq.wrData;
        end
        if (regReq.wrEn && regReq.addr == amc_pkg::ADDR_PRESCALE_OSR) begin
            cfg1Next = regReq.wrData;
        end
        stateD.modeClockBiasConfig      = cfg0Next;
        stateD.prescaleOversampleConfig = cfg1Next;
        if (regReq.rdEn) begin
            case (regReq.addr)
                amc_pkg::ADDR_MODE_CLOCK_BIAS: stateD.rdData = stateQ.modeClockBiasConfig;
                amc_pkg::ADDR_PRESCALE_OSR:    stateD.rdData = stateQ.prescaleOversampleConfig;
                default:                       stateD.rdData = amc_pkg::READ_UNMAPPED;
            endcase
        end

        modeCode = cfg0Next[amc_pkg::MODE_MSB:amc_pkg::MODE_LSB];
        clkCode  = cfg0Next[amc_pkg::CLKSEL_MSB:amc_pkg::CLKSEL_LSB];
        preCode  = cfg1Next[amc_pkg::PRE_MSB:amc_pkg::PRE_LSB];

        // Operating mode decode; both low codes mean shutdown.
        stateD.ctrl.convEn   = (modeCode == amc_pkg::MODE_CONVERT);
        stateD.ctrl.standby  = (modeCode == amc_pkg::MODE_STANDBY);
        stateD.ctrl.shutdown = !modeCode[1];
        // The guard bits only matter through this all-zero test.
        stateD.ctrl.fullShutdown = (cfg0Next == 8'h00);

        // Clock source: only the two high codes select the internal oscillator.
        stateD.ctrl.internalClock = clkCode[1];
        stateD.clkPinOe = (clkCode == amc_pkg::CLK_INTERNAL_OUT);

        case (cfg0Next[amc_pkg::BIAS_MSB:amc_pkg::BIAS_LSB])
            2'b11:   stateD.ctrl.biasNanoAmp = amc_pkg::BIAS_NA_HIGH;
            2'b10:   stateD.ctrl.biasNanoAmp = amc_pkg::BIAS_NA_MID;
            2'b01:   stateD.ctrl.biasNanoAmp = amc_pkg::BIAS_NA_LOW;
            default: stateD.ctrl.biasNanoAmp = amc_pkg::BIAS_NA_OFF;
        endcase

        stateD.ctrl.prescaleDivisor   = 4'h1 << preCode;
        stateD.ctrl.oversamplingRatio = osrOf(cfg1Next[amc_pkg::OSR_MSB:amc_pkg::OSR_LSB]);

        // Divider: a tick when all masked counter bits are set gives one pulse per period.
        // The pin carries the tick stream, so at divide-by-one it stays high; a trade for
        // keeping one clock domain instead of gating the master clock onto the pin.
        mask = preMask(stateQ.prescaleOversampleConfig[amc_pkg::PRE_MSB:amc_pkg::PRE_LSB]);
        stateD.divCnt = 3'(stateQ.divCnt + 3'h1);
        stateD.analogMasterClockTick = ((stateQ.divCnt & mask) == mask);
        stateD.clkPinOut = stateD.analogMasterClockTick && stateD.clkPinOe;
    end

    // State register with synchronous reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateQ <= '{modeClockBiasConfig:      amc_pkg::RST_MODE_CLOCK_BIAS,
                        prescaleOversampleConfig: amc_pkg::RST_PRESCALE_OSR,
                        ctrl: '{shutdown: 1'b1, prescaleDivisor: 4'h1,
                                oversamplingRatio: 17'h00100, default: '0},
                        default: '0};
        end else begin
            stateQ <= stateD;
        end
    end

    // Outputs straight from the state register.
    assign regRdData             = stateQ.rdData;
    assign clkPinOut             = stateQ.clkPinOut;
    assign clkPinOe              = stateQ.clkPinOe;
    assign analogMasterClockTick = stateQ.analogMasterClockTick;
    assign ctrl                  = stateQ.ctrl;

    // The external clock pin is only observed by the system clock tree outside this block.
    logic clkPinSeen;
    assign clkPinSeen = clkPinIn && !stateQ.ctrl.internalClock;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seqCfg0Write(logic [7:0] v);
        regReq.wrEn && regReq.addr == amc_pkg::ADDR_MODE_CLOCK_BIAS && regReq.wrData == v;
    endsequence

    AST_FULL_SHUTDOWN_ZERO: assert property (seqCfg0Write(8'h00) |=> ctrl.fullShutdown)
        else $error("All-zero write did not force full shutdown.");
    AST_GUARD_INERT: assert property (seqCfg0Write(8'h00 | 8'h80) |=> !ctrl.fullShutdown && ctrl.shutdown)
        else $error("Guard bit alone changed behaviour.");
    // A write may legally turn the pin off or change the divisor before the next tick,
    // so an attempt that sees any write is abandoned rather than reported.
    AST_CLK_OUT: assert property (disable iff (!rst_n || regReq.wrEn)
        ctrl.internalClock && clkPinOe |-> ##[0:8] clkPinOut)
        else $error("Clock pin silent while internal clock output selected.");
    AST_CLK_NO_OUT: assert property (!clkPinOe |-> !clkPinOut)
        else $error("Clock pin driven without output enable.");
    AST_CLK_EXT: assert property (seqCfg0Write(8'h10) |=> !ctrl.internalClock && !clkPinOe)
        else $error("External clock code did not release the pin.");
    AST_BIAS_HIGH: assert property (seqCfg0Write(8'h0C) |=> ctrl.biasNanoAmp == 14'h3A98)
        else $error("Bias code 11 did not select 15 uA.");
    AST_MODE_CONV: assert property (seqCfg0Write(8'h03) |=> ctrl.convEn && !ctrl.standby)
        else $error("Mode 11 did not enable conversions.");
    AST_MODE_STBY: assert property (ctrl.standby |-> !ctrl.convEn && !ctrl.shutdown)
        else $error("Standby overlaps another mode.");
    AST_MODE_SHDN: assert property (seqCfg0Write(8'h01) |=> ctrl.shutdown && !ctrl.convEn)
        else $error("Mode 01 did not shut down.");
    // A new prescaler value may legally restart the tick spacing, so writes abandon the attempt.
    AST_DIV_TICK: assert property (disable iff (!rst_n || regReq.wrEn)
        ctrl.prescaleDivisor == 4'h8 && analogMasterClockTick
        && $stable(ctrl.prescaleDivisor) |=> !analogMasterClockTick [*7])
        else $error("Divide-by-eight tick came early.");
    AST_OSR_MAX: assert property (regReq.wrEn && regReq.addr == amc_pkg::ADDR_PRESCALE_OSR
        && regReq.wrData[5:2] == 4'hF |=> ctrl.oversamplingRatio == 17'h18000)
        else $error("Code 1111 did not select ratio 98304.");

endmodule : amc_config_regs

// ==== sim/amc_config_regs_test.sv ====
// Purpose: Self-checking bench for the mode, clock, bias, prescale and oversampling registers.
// Assumes: Requests start 1 ns after a rising edge; results are settled 1 ns after the next.
// Notes:   A bench model of both registers predicts every read and every decoded control.
`timescale 1ns/100ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module amc_config_regs_test;
    logic               clk;
    logic               rst_n;
    amc_pkg::amc_req_t  regReq;
    logic [7:0]         regRdData;
    logic               clkPinIn;
    logic               clkPinOut;
    logic               clkPinOe;
    logic               analogMasterClockTick;
    amc_pkg::amc_ctrl_t ctrl;
    integer             num_errors = 0;
    integer             checks = 0;
    integer             seed = 12;
    integer             modelCfg0;
    integer             modelCfg1;
    integer             i;
    integer             biasNa [4] = '{0, 900, 3700, 15000};
    integer             osrTab [16] = '{32, 64, 128, 256, 512, 1024, 2048, 4096, 8192,
                                        16384, 20480, 24576, 40960, 49152, 81920, 98304};

    amc_config_regs dut (.clk(clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
        .clkPinIn(clkPinIn), .clkPinOut(clkPinOut), .clkPinOe(clkPinOe),
        .analogMasterClockTick(analogMasterClockTick), .ctrl(ctrl));

    // Decoded controls predicted from the two model registers.
    function automatic amc_pkg::amc_ctrl_t expCtrl();
        amc_pkg::amc_ctrl_t e;
        e.convEn            = (modelCfg0 & 3) == 3;
        e.standby           = (modelCfg0 & 3) == 2;
        e.shutdown          = (modelCfg0 & 3) < 2;
        e.fullShutdown      = modelCfg0 == 0;
        e.internalClock     = ((modelCfg0 >> 5) & 1) == 1;
        e.biasNanoAmp       = 14'(biasNa[(modelCfg0 >> 2) & 3]);
        e.prescaleDivisor   = 4'(1 << ((modelCfg1 >> 6) & 3));
        e.oversamplingRatio = 17'(osrTab[(modelCfg1 >> 2) & 15]);
        return e;
    endfunction : expCtrl

    // One request; the request is not cleared here so that accesses run back to back.
    task automatic acc(input logic wr, input logic rd, input logic [3:0] a, input logic [7:0] d);
        integer old;
        old = (a == 4'h1) ? modelCfg0 : (a == 4'h2) ? modelCfg1 : 0;
        regReq = '{wrEn: wr, rdEn: rd, addr: a, wrData: d};
        @(posedge clk);
        #1;
        if (wr && a == 4'h1) modelCfg0 = d;
        if (wr && a == 4'h2) modelCfg1 = d;
        if (rd) `CHK("readback", 8'(old), regRdData)
        `CHK("ctrl", expCtrl(), ctrl)
        `CHK("clock pin enable", ((modelCfg0 >> 4) & 3) == 3, clkPinOe)
    endtask : acc

    // Counts analog clock ticks over 16 cycles for one prescaler code.
    task automatic tickCount(input integer p);
        integer n;
        acc(1'b1, 1'b0, 4'h2, 8'(p << 6));
        regReq = '0;
        repeat (10) @(posedge clk);
        n = 0;
        repeat (16) begin
            @(posedge clk);
            #1;
            if (analogMasterClockTick === 1'b1) n++;
            if (clkPinOe === 1'b1) `CHK("pin out", analogMasterClockTick, clkPinOut)
        end
        `CHK("tick count", 16 >> p, n)
    endtask : tickCount

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // The pin input toggles so that an external clock is present; it must not disturb state.
    initial begin
        clkPinIn = 1'b0;
        forever begin
            @(posedge clk);
            #1;
            clkPinIn = ~clkPinIn;
        end
    end

    // Watchdog: the run is far shorter than this, so reaching it means a hang.
    initial begin
        #100000;
        num_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        end_sim();
    end

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        regReq = '0;
        modelCfg0 = 8'hC0;
        modelCfg1 = 8'h0C;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        `CHK("ctrl at reset", expCtrl(), ctrl)
        // Every value of the first register, read in the same cycle as written: old data back.
        for (i = 0; i < 256; i++) acc(1'b1, 1'b1, 4'h1, 8'(i));
        acc(1'b0, 1'b1, 4'h1, 8'h00);
        for (i = 0; i < 256; i++) acc(1'b1, 1'b1, 4'h2, 8'(i));
        acc(1'b1, 1'b0, 4'h1, 8'h30);
        for (i = 0; i < 4; i++) tickCount(i);
        // Unmapped places ignore writes and read as zero.
        acc(1'b1, 1'b1, 4'hF, 8'h55);
        acc(1'b0, 1'b1, 4'h0, 8'h00);
        repeat (60) acc(1'($random(seed)), 1'($random(seed)), 4'($random(seed) & 3),
                        8'($random(seed)));
        // A second reset in mid-run restores the reset values.
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        modelCfg0 = 8'hC0;
        modelCfg1 = 8'h0C;
        `CHK("ctrl after reset", expCtrl(), ctrl)
        acc(1'b0, 1'b1, 4'h1, 8'h00);
        acc(1'b0, 1'b1, 4'h2, 8'h00);
        end_sim();
    end
endmodule : amc_config_regs_test
